// file: verification/lf_tx_model.sv
// Behavioural low-frequency transmitter driving the detector lines.
`timescale 1ns/1ps
module lf_tx_model
(
	input  wire logic        clock_i,                  // System clock
	input  wire logic        start_i,                  // Begin one transmission
	input  wire logic        manch_i,                  // 1 sends preamble, sync and frame
	input  wire logic [31:0] pre_len_i,                // Preamble length, cycles
	input  wire logic [31:0] len_i,                    // Whole burst length, cycles
	output logic             detect_o,                 // Carrier seen by the detector
	output logic             preamble_o                // Preamble zeros seen
);
	// ---------------------------------------------------------------
	// Burst timing
	// ---------------------------------------------------------------
	logic [31:0] cnt_reg;                              // Cycles since start, saturates

	initial cnt_reg = 32'hFFFF_FFFF;
	// Count from the start request; parks at all ones when idle
	always @(posedge clock_i)
	begin
		if (start_i)
			cnt_reg <= 32'h0000_0000;
		else if (cnt_reg != 32'hFFFF_FFFF)
			cnt_reg <= cnt_reg + 32'h0000_0001;
	end
	// Carrier for the whole burst; sync and frame follow the zeros
	assign detect_o = (cnt_reg < len_i);
	// Zeros lead the burst; length set by the caller to cover a period
	assign preamble_o = manch_i && (cnt_reg < pre_len_i);
endmodule

// file: verification/lf_wakeup_sampler_tb.sv
// Self-checking testbench for the low-frequency wake-up sampler.
`timescale 1ns/1ps
module lf_wakeup_sampler_tb;
	import lf_wakeup_pkg::*;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        clock_i, rst_i, psel, penable, pwrite;  // Clock, reset, APB
	logic [7:0]  paddr;                                // APB address
	logic [31:0] pwdata, prdata, rd;                   // APB data, last read
	logic        pready, pslverr, err_s, irq;          // Answers
	logic        detect, pre, pin_in, port_out, port_oe;  // Inputs
	logic        port_in, pin_out, pin_oe;             // Pin outputs
	logic        tx_go, tx_man;                        // Transmitter control
	logic [31:0] tx_pre, tx_len;                       // Transmitter lengths
	int          n_fail, tests_run, cyc;               // Counters

	// Clock of 100 ns
	initial
	begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end

	// Short wake period keeps the run brief
	lf_wakeup_sampler #(.INTERVAL_DEFAULT(32'h0000_0FA0)) dut_u (.clock_i(clock_i),
		.rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .detect_i(detect), .preamble_i(pre), .pin_in_i(pin_in),
		.port_out_i(port_out), .port_oe_i(port_oe), .port_in_o(port_in),
		.pin_out_o(pin_out), .pin_oe_o(pin_oe), .irq_o(irq));
	lf_tx_model tx_u (.clock_i(clock_i), .start_i(tx_go), .manch_i(tx_man),
		.pre_len_i(tx_pre), .len_i(tx_len), .detect_o(detect), .preamble_o(pre));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; waits for pready, takes data at that edge
	// Only the global timeout ends a stuck wait
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do
			@(posedge clock_i);
		while (pready !== 1'b1);
		rd = prdata;
		err_s = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Start the transmitter for one burst
	task automatic send(input logic m, input logic [31:0] p, input logic [31:0] n);
		tx_man <= m;
		tx_pre <= p;
		tx_len <= n;
		tx_go <= 1'b1;
		@(posedge clock_i);
		tx_go <= 1'b0;
	endtask
	// Bounded wait for the interrupt line
	task automatic wait_irq(input int lim);
		int k;
		k = 0;
		while (irq !== 1'b1 && k < lim)
		begin
			@(posedge clock_i);
			k++;
		end
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		apb(0, ADDR_CTRL, 0);
		chk(rd, 32'h0);
		apb(0, ADDR_INTERVAL, 0);
		chk(rd, 32'h0000_0FA0);
		apb(0, ADDR_ONTIME, 0);
		chk(rd, ONTIME_RST);
		apb(0, ADDR_QUALIFY, 0);
		chk(rd, QUALIFY_RST);
		apb(0, ADDR_STATUS, 0);
		chk(rd, 32'h0);
		chk(err_s, 32'h0);
		// Unmapped place is refused and reads zero
		apb(0, 8'h1C, 0);
		chk({rd[30:0], err_s}, 32'h1);
		// Idle receiver leaves the pins to the port
		chk({port_in, pin_out, pin_oe}, 32'h7);
		port_out <= 1'b0;
		pin_in <= 1'b0;
		@(posedge clock_i);
		chk({port_in, pin_out, pin_oe}, 32'h1);
		$display("done reset");
	endtask
	task automatic t_phases();
		apb(1, ADDR_CTRL, 32'h1);
		repeat (100) @(posedge clock_i);
		apb(0, ADDR_STATE, 0);
		chk(rd[4:0], 32'h04);
		chk(pin_oe, 32'h0);
		repeat (700) @(posedge clock_i);
		apb(0, ADDR_STATE, 0);
		chk(rd[6:0], 32'h68);
		repeat (1300) @(posedge clock_i);
		apb(0, ADDR_STATE, 0);
		chk(rd[4:0], 32'h02);
		repeat (2000) @(posedge clock_i);
		apb(0, ADDR_STATE, 0);
		chk(rd[4:0], 32'h04);
		apb(1, ADDR_CTRL, 0);
		apb(0, ADDR_STATE, 0);
		chk(rd[4:0], 32'h01);
		$display("done phases");
	endtask
	task automatic t_carrier();
		// Controls first, enable last
		apb(1, ADDR_QUALIFY, 32'd20);
		apb(1, ADDR_MASK, 32'h3);
		// Carrier dropping before the qualify time sets nothing
		send(0, 0, 32'd715);
		apb(1, ADDR_CTRL, 32'h1);
		repeat (1000) @(posedge clock_i);
		chk({irq, dut_u.irq_o}, 32'h0);
		send(0, 0, 32'd8000);
		wait_irq(6000);
		apb(0, ADDR_STATUS, 0);
		chk(rd, 32'h1);
		repeat (50) @(posedge clock_i);
		chk(irq, 32'h1);
		apb(1, ADDR_CTRL, 0);
		apb(1, ADDR_STATUS, 32'h1);
		@(posedge clock_i);
		chk(irq, 32'h0);
		$display("done carrier");
	endtask
	task automatic t_manch();
		// Waking in sync or frame finds no preamble
		send(1, 32'd300, 32'd2500);
		apb(1, ADDR_CTRL, 32'h3);
		repeat (1500) @(posedge clock_i);
		apb(0, ADDR_STATUS, 0);
		chk(rd, 32'h0);
		apb(1, ADDR_CTRL, 0);
		// Preamble of one period plus 8 bits of 16 cycles
		send(1, 32'd4128, 32'd6000);
		apb(1, ADDR_CTRL, 32'h3);
		wait_irq(6000);
		apb(0, ADDR_STATUS, 0);
		chk(rd, 32'h2);
		apb(1, ADDR_MASK, 0);
		@(posedge clock_i);
		chk(irq, 32'h0);
		apb(1, ADDR_MASK, 32'h2);
		@(posedge clock_i);
		chk(irq, 32'h1);
		apb(1, ADDR_CTRL, 0);
		apb(1, ADDR_STATUS, 32'h2);
		@(posedge clock_i);
		chk(irq, 32'h0);
		$display("done manchester");
	endtask

	// ---------------------------------------------------------------
	// Verdict, timeout and main sequence
	// ---------------------------------------------------------------
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Whole run needs about 11000 cycles; over three times that means a hang
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	initial
	begin
		rst_i = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = 43'h000_0000_0000;
		{pin_in, port_out, port_oe} = 3'h7;
		{tx_go, tx_man, tx_pre, tx_len} = 66'h0;
		{n_fail, tests_run} = 64'h0;
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		t_reset();
		t_phases();
		t_carrier();
		t_manch();
		give_verdict();
	end
endmodule

// file: verilog/lf_sample_seq.sv
// Sample sequencer: periodic power-up, auto-zero, window and qualification.
`timescale 1ns/1ps
module lf_sample_seq
	import lf_wakeup_pkg::*;
(
	input  wire logic     clock_i,                     // System clock
	input  wire logic     rst_i,                       // Synchronous reset
	input  wire rx_cfg_t  cfg_i,                       // Configuration
	input  wire logic     signal_i,                    // Detector output level
	input  wire logic     preamble_i,                  // Detector sees Manchester zeros
	output rx_stat_t      stat_o,                      // Events and live state
	output rx_state_t     state_o                      // Current state
);

	// ---------------------------------------------------------------
	// State and counters
	// ---------------------------------------------------------------
	rx_state_t        state_reg;                       // Sequencer state
	logic [CNT_W-1:0] period_cnt_reg;                  // Cycles since last power-up
	logic [CNT_W-1:0] phase_cnt_reg;                   // Cycles in current phase
	logic             carrier_ev_reg;                  // Qualified carrier pulse
	logic             msg_ev_reg;                      // Manchester message pulse

	localparam logic [CNT_W-1:0] AZ_LAST  = CNT_W'(AUTOZERO_CYC - 1);
	localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WINDOW_CYC - 1);

	// Period wraps so the wake interval does not drift with phases
	wire period_done = (period_cnt_reg >= cfg_i.interval - 32'h0000_0001);

	// ---------------------------------------------------------------
	// Period counter
	// ---------------------------------------------------------------
	// Runs only while enabled; zeroed on the first power-up so every period is full
	always_ff @(posedge clock_i)
	begin
		if (rst_i || !cfg_i.enable || state_reg == ST_OFF)
			period_cnt_reg <= '0;
		else if (period_done)
			period_cnt_reg <= '0;
		else
			period_cnt_reg <= period_cnt_reg + 32'h0000_0001;
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		carrier_ev_reg <= 1'b0;
		msg_ev_reg     <= 1'b0;
		if (rst_i)
		begin
			state_reg     <= ST_OFF;
			phase_cnt_reg <= '0;
		end
		else if (!cfg_i.enable)
		begin
			// Disabling stops everything at once
			state_reg     <= ST_OFF;
			phase_cnt_reg <= '0;
		end
		else
		begin
			phase_cnt_reg <= phase_cnt_reg + 32'h0000_0001;
			case (state_reg)
				ST_OFF:
				begin
					// First power-up right after enabling
					state_reg     <= ST_AUTOZERO;
					phase_cnt_reg <= '0;
				end
				ST_SLEEP:
				begin
					if (period_done)
					begin
						state_reg     <= ST_AUTOZERO;
						phase_cnt_reg <= '0;
					end
				end
				ST_AUTOZERO:
				begin
					// Input ignored while the offset is nulled
					if (phase_cnt_reg == AZ_LAST)
					begin
						state_reg     <= ST_SAMPLE;
						phase_cnt_reg <= '0;
					end
				end
				ST_SAMPLE:
				begin
					if (cfg_i.manchester && preamble_i)
					begin
						// Only a preamble wakes; sync or data is ignored
						msg_ev_reg    <= 1'b1;
						state_reg     <= ST_SLEEP;
					end
					else if (!cfg_i.manchester && signal_i)
					begin
						state_reg     <= ST_QUALIFY;
						phase_cnt_reg <= '0;
					end
					else if (phase_cnt_reg == WIN_LAST ||
						phase_cnt_reg + AZ_LAST + 32'h0000_0001 >= cfg_i.on_time)
					begin
						state_reg     <= ST_SLEEP;
					end
				end
				ST_QUALIFY:
				begin
					if (!signal_i)
						state_reg     <= ST_SLEEP;     // Dropped out before qualifying
					else if (phase_cnt_reg >= cfg_i.qualify - 32'h0000_0001)
					begin
						carrier_ev_reg <= 1'b1;
						state_reg      <= ST_SLEEP;
					end
				end
				default:
					state_reg <= ST_OFF;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign state_o              = state_reg;
	assign stat_o.carrier_event = carrier_ev_reg;
	assign stat_o.message_event = msg_ev_reg;
	assign stat_o.powered       = (state_reg == ST_AUTOZERO) || (state_reg == ST_SAMPLE) ||
		(state_reg == ST_QUALIFY);
	assign stat_o.sampling      = (state_reg == ST_SAMPLE);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_az_run;
		(state_reg == ST_AUTOZERO) [*8];
	endsequence

	a_autozero_hold: assert property (@(posedge clock_i) disable iff (rst_i || !cfg_i.enable)
		$rose(state_reg == ST_AUTOZERO) |-> s_az_run)
		else $error("auto-zero left too early");

	a_window_closes: assert property (@(posedge clock_i) disable iff (rst_i)
		(state_reg == ST_SAMPLE) |-> (phase_cnt_reg <= WIN_LAST))
		else $error("sampling window overran");

	a_sample_after_az: assert property (@(posedge clock_i) disable iff (rst_i || !cfg_i.enable)
		$rose(state_reg == ST_SAMPLE) |-> $past(state_reg) == ST_AUTOZERO)
		else $error("window opened without auto-zero");

	a_qualify_first: assert property (@(posedge clock_i) disable iff (rst_i)
		carrier_ev_reg |-> $past(state_reg) == ST_QUALIFY && $past(signal_i))
		else $error("carrier event without qualification");

	a_msg_preamble: assert property (@(posedge clock_i) disable iff (rst_i)
		msg_ev_reg |-> $past(state_reg) == ST_SAMPLE && $past(preamble_i))
		else $error("message wake outside preamble");

	a_wake_period: assert property (@(posedge clock_i) disable iff (rst_i || !cfg_i.enable)
		$rose(state_reg == ST_AUTOZERO) && $past(state_reg) == ST_SLEEP |->
		$past(period_done))
		else $error("wake off the sample interval");

endmodule

// file: verilog/lf_wakeup_pkg.sv
// Package of constants and types for the low-frequency wake-up sampler.
package lf_wakeup_pkg;

	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS       = 100;          // 10 MHz system clock
	localparam int SAMPLE_INTERVAL_MS  = 1024;         // Default wake period
	localparam int ON_TIME_US          = 200;          // Default active on-time
	localparam int AUTOZERO_MIN_US     = 60;           // Auto-zero, low end
	localparam int AUTOZERO_MAX_US     = 70;           // Auto-zero, high end
	localparam int WINDOW_US           = 128;          // Sampling window
	localparam int QUALIFY_US          = 1000;         // Default carrier qualify time
	localparam int MS_NS               = 1000000;
	localparam int US_NS               = 1000;
	// Cycle counts: the auto-zero wait takes the longest value rounded up
	localparam int ON_TIME_CYC   = (ON_TIME_US * US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AUTOZERO_CYC  = (AUTOZERO_MAX_US * US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WINDOW_CYC    = (WINDOW_US * US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QUALIFY_CYC   = (QUALIFY_US * US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INTERVAL_CYC  = SAMPLE_INTERVAL_MS * (MS_NS / CLK_PERIOD_NS);
	localparam int CNT_W         = 32;

	// ---------------------------------------------------------------
	// Register map (APB byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL     = 8'h00;      // Enable, mode
	localparam logic [7:0] ADDR_INTERVAL = 8'h04;      // Sample interval, cycles
	localparam logic [7:0] ADDR_ONTIME   = 8'h08;      // Sample on-time, cycles
	localparam logic [7:0] ADDR_QUALIFY  = 8'h0C;      // Carrier qualify time, cycles
	localparam logic [7:0] ADDR_STATUS   = 8'h10;      // Sticky flags, write one clears
	localparam logic [7:0] ADDR_MASK     = 8'h14;      // Interrupt mask
	localparam logic [7:0] ADDR_STATE    = 8'h18;      // Live state, read only

	// Control fields
	localparam int CTRL_EN_BIT   = 0;                  // Receiver enable bit
	localparam int CTRL_MODE_BIT = 1;                  // 0 carrier, 1 Manchester
	// Status fields
	localparam int ST_CARRIER_BIT = 0;                 // Carrier detect flag
	localparam int ST_MSG_BIT     = 1;                 // Manchester preamble wake
	localparam int ST_W           = 2;

	// Reset values
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	localparam logic [31:0] ONTIME_RST   = 32'(ON_TIME_CYC);
	localparam logic [31:0] QUALIFY_RST  = 32'(QUALIFY_CYC);
	localparam logic [ST_W-1:0] MASK_RST = 2'h0;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_OFF     = 5'h01,                            // Receiver disabled
		ST_SLEEP   = 5'h02,                            // Powered down between samples
		ST_AUTOZERO= 5'h04,                            // Offset nulling
		ST_SAMPLE  = 5'h08,                            // Sampling window open
		ST_QUALIFY = 5'h10                             // Monitoring a detected signal
	} rx_state_t;

	typedef struct packed {
		logic        enable;                           // Receiver enable bit
		logic        manchester;                       // Manchester data operation
		logic [31:0] interval;                         // Sample interval cycles
		logic [31:0] on_time;                          // Sample on-time setting
		logic [31:0] qualify;                          // Carrier qualify time
	} rx_cfg_t;

	typedef struct packed {
		logic carrier_event;                           // Carrier qualified pulse
		logic message_event;                           // Preamble acquired pulse
		logic powered;                                 // Front end powered
		logic sampling;                                // Window open
	} rx_stat_t;

endpackage

// file: verilog/lf_wakeup_sampler.sv
// Top level: APB registers, interrupt and pin sharing around the sequencer.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

module lf_wakeup_sampler
	import lf_wakeup_pkg::*;
#(
	parameter logic [31:0] INTERVAL_DEFAULT = 32'(INTERVAL_CYC)  // Wake period, cycles
)
(
	input  wire logic        clock_i,                  // System clock
	input  wire logic        rst_i,                    // Synchronous reset
	input  wire logic        psel_i,                   // APB select
	input  wire logic        penable_i,                // APB enable
	input  wire logic        pwrite_i,                 // APB direction
	input  wire logic [7:0]  paddr_i,                  // APB byte address
	input  wire logic [31:0] pwdata_i,                 // APB write data
	output logic [31:0]      prdata_o,                 // APB read data
	output logic             pready_o,                 // APB ready
	output logic             pslverr_o,                // APB error
	input  wire logic        detect_i,                 // Detector carrier level
	input  wire logic        preamble_i,               // Detector sees preamble
	input  wire logic        pin_in_i,                 // Pad input level
	input  wire logic        port_out_i,               // Port data when pin is an output
	input  wire logic        port_oe_i,                // Port drive request
	output logic             port_in_o,                // Pad level to the port logic
	output logic             pin_out_o,                // Pad drive value
	output logic             pin_oe_o,                 // Pad drive enable
	output logic             irq_o                     // Level interrupt
);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic            enable_reg;                       // Receiver enable bit
	logic            mode_reg;                         // Manchester mode select
	logic [31:0]     interval_reg;                     // Sample interval
	logic [31:0]     ontime_reg;                       // Sample on-time setting
	logic [31:0]     qualify_reg;                      // Carrier qualify time
	logic [ST_W-1:0] status_reg;                       // Sticky flags
	logic [ST_W-1:0] mask_reg;                         // Interrupt mask
	logic [31:0]     prdata_reg;                       // Read data
	logic            pslverr_reg;                      // Error answer
	rx_cfg_t         cfg;                              // Config bundle
	rx_stat_t        stat;                             // Sequencer events
	rx_state_t       state;                            // Sequencer state
	logic [ST_W-1:0] events;                           // Event vector
	logic            wr_en;                            // Write access phase
	logic            rd_en;                            // Read access phase

	// Single-cycle slave: every access finishes in its first access cycle
	assign wr_en     = psel_i && penable_i && pwrite_i;
	assign rd_en     = psel_i && penable_i && !pwrite_i;
	assign pready_o  = 1'b1;
	assign prdata_o  = prdata_reg;
	assign pslverr_o = pslverr_reg;

	// Decode shared by read and write paths
	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == ADDR_CTRL) || (a == ADDR_INTERVAL) || (a == ADDR_ONTIME) ||
			(a == ADDR_QUALIFY) || (a == ADDR_STATUS) || (a == ADDR_MASK) ||
			(a == ADDR_STATE);
	endfunction

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	// Settings are taken as written; software finishes them before enabling
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			enable_reg   <= CTRL_RST[CTRL_EN_BIT];
			mode_reg     <= CTRL_RST[CTRL_MODE_BIT];
			interval_reg <= INTERVAL_DEFAULT;
			ontime_reg   <= ONTIME_RST;
			qualify_reg  <= QUALIFY_RST;
			mask_reg     <= MASK_RST;
		end
		else if (wr_en)
		begin
			if (paddr_i == ADDR_CTRL)
			begin
				enable_reg <= pwdata_i[CTRL_EN_BIT];
				mode_reg   <= pwdata_i[CTRL_MODE_BIT];
			end
			else if (paddr_i == ADDR_INTERVAL)
				interval_reg <= pwdata_i;
			else if (paddr_i == ADDR_ONTIME)
				ontime_reg <= pwdata_i;
			else if (paddr_i == ADDR_QUALIFY)
				qualify_reg <= pwdata_i;
			else if (paddr_i == ADDR_MASK)
				mask_reg <= pwdata_i[ST_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// Sticky status
	// ---------------------------------------------------------------
	// Set beats clear so an event in the clearing cycle survives
	assign events[ST_CARRIER_BIT] = stat.carrier_event;
	assign events[ST_MSG_BIT]     = stat.message_event;

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			status_reg <= '0;
		else if (wr_en && paddr_i == ADDR_STATUS)
			status_reg <= (status_reg & ~pwdata_i[ST_W-1:0]) | events;
		else
			status_reg <= status_reg | events;
	end

	// Level interrupt holds while any unmasked flag is set
	assign irq_o = |(status_reg & mask_reg);

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			// Error answer is staged in setup and held until the next setup
			if (psel_i && !penable_i)
				pslverr_reg <= !addr_known(paddr_i);
			if (psel_i && !penable_i && !pwrite_i)
			begin
				// Data staged in setup so it is on the bus in the access cycle
				if (paddr_i == ADDR_CTRL)
					prdata_reg <= {30'h0, mode_reg, enable_reg};
				else if (paddr_i == ADDR_INTERVAL)
					prdata_reg <= interval_reg;
				else if (paddr_i == ADDR_ONTIME)
					prdata_reg <= ontime_reg;
				else if (paddr_i == ADDR_QUALIFY)
					prdata_reg <= qualify_reg;
				else if (paddr_i == ADDR_STATUS)
					prdata_reg <= {30'h0, status_reg};
				else if (paddr_i == ADDR_MASK)
					prdata_reg <= {30'h0, mask_reg};
				else if (paddr_i == ADDR_STATE)
					prdata_reg <= {25'h0, stat.sampling, stat.powered, state};
				else
					prdata_reg <= 32'h0000_0000;
			end
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	assign cfg.enable     = enable_reg;
	assign cfg.manchester = mode_reg;
	assign cfg.interval   = interval_reg;
	assign cfg.on_time    = ontime_reg;
	assign cfg.qualify    = qualify_reg;

	lf_sample_seq u_seq (
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.cfg_i      (cfg),
		.signal_i   (detect_i),
		.preamble_i (preamble_i),
		.stat_o     (stat),
		.state_o    (state)
	);

	// ---------------------------------------------------------------
	// Pin sharing
	// ---------------------------------------------------------------
	// Disabled receiver hands the pad to the port; enabled keeps it an input
	assign port_in_o = pin_in_i;
	assign pin_out_o = enable_reg ? 1'b0 : port_out_i;
	assign pin_oe_o  = enable_reg ? 1'b0 : port_oe_i;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_flag_sticky: assert property (@(posedge clock_i) disable iff (rst_i)
		status_reg[ST_CARRIER_BIT] && !(wr_en && paddr_i == ADDR_STATUS &&
		pwdata_i[ST_CARRIER_BIT]) |=> status_reg[ST_CARRIER_BIT])
		else $error("carrier flag dropped without clear");

	a_flag_sets: assert property (@(posedge clock_i) disable iff (rst_i)
		stat.carrier_event |=> status_reg[ST_CARRIER_BIT])
		else $error("carrier event not recorded");

	a_irq_level: assert property (@(posedge clock_i) disable iff (rst_i)
		status_reg[ST_CARRIER_BIT] && mask_reg[ST_CARRIER_BIT] |-> irq_o)
		else $error("interrupt not held");

	a_pin_released: assert property (@(posedge clock_i) disable iff (rst_i)
		!enable_reg |-> pin_oe_o == port_oe_i && pin_out_o == port_out_i)
		else $error("port does not own idle pin");

	a_off_when_disabled: assert property (@(posedge clock_i) disable iff (rst_i)
		!enable_reg |=> !stat.powered)
		else $error("front end powered while disabled");

endmodule
